// [hdl/packet_defines.svh]
`ifndef PACKET_DEFINES_SVH
`define PACKET_DEFINES_SVH

// framing bytes
`define DLE_BYTE        8'h10
`define ETX_BYTE        8'h03
`define ERR_ECHO_ID     8'h13

// commands taken from the host
`define CMD_CLEAR_RESET 8'h1E
`define CMD_VERSION     8'h1F
`define CMD_TIME        8'h21
`define CMD_SEED_XYZ    8'h23
`define CMD_FIX_MODE    8'h24
`define CMD_SOFT_RESET  8'h25
`define CMD_HEALTH      8'h26
`define CMD_SIGNALS     8'h27
`define CMD_SYS_MSG     8'h28
`define CMD_ALTITUDE    8'h2A

// reports sent to the host
`define REP_TIME        8'h41
`define REP_VERSION     8'h45
`define REP_HEALTH      8'h46
`define REP_SIGNALS     8'h47
`define REP_SYS_MSG     8'h48
`define REP_ALTITUDE    8'h4A
`define REP_STATUS      8'h4B
`define REP_FIX_MODE    8'h6D

// payload values
`define MODE_COLD       8'h4B
`define MODE_FACTORY    8'h46
`define ALT_CLEAR_FLAG  8'hFF

// payload lengths and storage
`define BUF_DEPTH       16
`define BUF_AW          4
`define LEN_W           5
`define LEN_FULL        5'h10
`define LEN_SEED        5'h0C
`define LEN_ALT_SET     5'h04
`define LEN_ONE         5'h01
`define LEN_ALT_REPORT  5'h05
`define FIFO_DEPTH      4
`define ALT_RESET       32'h0000_0000

`endif

// [hdl/packet_pkg.sv]
package packet_pkg;

  typedef enum logic [2:0] {
    st_hunt = 3'h0,
    st_id   = 3'h1,
    st_data = 3'h3,
    st_esc  = 3'h2,
    st_send = 3'h6
  } rx_state_type;

  typedef enum logic [2:0] {
    ph_lead  = 3'h0,
    ph_err   = 3'h1,
    ph_id    = 3'h3,
    ph_data  = 3'h2,
    ph_stuff = 3'h6,
    ph_taild = 3'h7,
    ph_taile = 3'h5
  } tx_phase_type;

endpackage

// [hdl/byte_fifo.sv]
`timescale 1ns/1ps

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push_w;
  wire              pop_w;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_out  = (count_reg != (AW + 1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push_w        = in_valid_in && in_ready_out;
  assign pop_w         = out_valid_out && out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop_w) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      count_reg <= count_reg + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (push_w) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

endmodule

// [hdl/packet_command.sv]
`timescale 1ns/1ps
`include "packet_defines.svh"

module packet_command (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  output logic             rx_ready_out,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  input  wire logic        tx_ready_in,
  input  wire logic        computing_in,
  input  wire logic        msg_received_in,
  input  wire logic [31:0] last_3d_altitude_in,
  output logic             restart_out,
  output logic             erase_battery_backed_memory_out,
  output logic             erase_serial_nonvolatile_store_out,
  output logic             seed_valid_out,
  output logic [31:0]      seed_x_out,
  output logic [31:0]      seed_y_out,
  output logic [31:0]      seed_z_out,
  output logic [31:0]      ref_altitude_out,
  output logic             altitude_flag_out,
  output logic [31:0]      altitude_2d_out
);
  import packet_pkg::*;

  packet_pkg::rx_state_type state_reg, state_next;
  packet_pkg::tx_phase_type phase_reg, phase_next;
  logic [7:0]          buf_reg [`BUF_DEPTH];
  logic [7:0]          rx_id_reg;
  logic [`LEN_W-1:0]   rx_len_reg;
  logic                rx_bad_reg;
  logic                rx_ready_reg;
  logic [7:0]          tx_id_reg;
  logic [`LEN_W-1:0]   tx_len_reg;
  logic [`LEN_W-1:0]   tx_idx_reg, tx_idx_next;
  logic                tx_echo_reg;
  logic                tx_more_reg;
  logic                tx_valid_reg;
  logic [7:0]          tx_data_reg;
  logic [31:0]         seed_reg [3];
  logic                seed_valid_reg;
  logic [31:0]         ref_alt_reg;
  logic                alt_flag_reg;
  logic [31:0]         alt_2d_reg;
  logic                restart_reg;
  logic                erase_bbm_reg;
  logic                erase_store_reg;
  logic [7:0]          last_push_reg;

  wire                 rx_take      = rx_valid_in && rx_ready_reg;
  wire                 rx_is_dle    = (rx_data_in == `DLE_BYTE);
  wire                 rx_is_etx    = (rx_data_in == `ETX_BYTE);
  wire                 id_ok        = !rx_is_dle && !rx_is_etx;
  wire                 in_id        = (state_reg == st_id);
  wire                 in_data      = (state_reg == st_data);
  wire                 in_esc       = (state_reg == st_esc);
  wire                 rx_store     = rx_take && ((in_data && !rx_is_dle) || (in_esc && rx_is_dle));
  wire                 stuff_err    = rx_take && in_esc && !rx_is_dle && !rx_is_etx;
  wire                 rx_full      = (rx_len_reg == `LEN_FULL);
  wire                 frame_end    = rx_take && in_esc && rx_is_etx;
  wire [7:0]           b0           = buf_reg[0];
  wire                 len0         = (rx_len_reg == '0);
  wire                 len1         = (rx_len_reg == `LEN_ONE);

  // command decode at the end of a frame
  wire                 is_reset     = (rx_id_reg == `CMD_CLEAR_RESET);
  wire                 is_seed      = (rx_id_reg == `CMD_SEED_XYZ);
  wire                 is_alt       = (rx_id_reg == `CMD_ALTITUDE);
  wire                 is_soft      = (rx_id_reg == `CMD_SOFT_RESET);
  wire                 is_health    = (rx_id_reg == `CMD_HEALTH);
  wire                 is_msg       = (rx_id_reg == `CMD_SYS_MSG);
  wire                 ok_reset     = is_reset && len1 && (b0 == `MODE_COLD || b0 == `MODE_FACTORY);
  wire                 ok_query     = len0 && (rx_id_reg == `CMD_VERSION || rx_id_reg == `CMD_TIME ||
                                      rx_id_reg == `CMD_FIX_MODE || is_soft || is_health ||
                                      rx_id_reg == `CMD_SIGNALS || is_msg);
  wire                 ok_seed      = is_seed && (rx_len_reg == `LEN_SEED);
  wire                 alt_set      = is_alt && (rx_len_reg == `LEN_ALT_SET);
  wire                 alt_clear    = is_alt && len1 && (b0 == `ALT_CLEAR_FLAG);
  wire                 ok_alt       = alt_set || alt_clear || (is_alt && len0);
  wire                 parsed       = !rx_bad_reg && (ok_reset || ok_query || ok_seed || ok_alt);
  wire                 reply_none   = ok_seed || (is_msg && !msg_received_in);
  wire                 tx_load      = frame_end && !(parsed && reply_none);
  wire                 do_act       = frame_end && parsed;
  wire                 seed_load    = do_act && ok_seed && !computing_in;
  wire [7:0]           reply_id     = ok_reset                         ? `REP_STATUS   :
                                      (rx_id_reg == `CMD_VERSION)      ? `REP_VERSION  :
                                      (rx_id_reg == `CMD_TIME)         ? `REP_TIME     :
                                      (rx_id_reg == `CMD_FIX_MODE)     ? `REP_FIX_MODE :
                                      is_soft                          ? `REP_VERSION  :
                                      is_health                        ? `REP_HEALTH   :
                                      (rx_id_reg == `CMD_SIGNALS)      ? `REP_SIGNALS  :
                                      is_msg                           ? `REP_SYS_MSG  :
                                                                         `REP_ALTITUDE;

  // transmit byte selection
  wire [39:0]          alt_word     = {ref_alt_reg, 7'h00, alt_flag_reg};
  wire [7:0]           alt_byte     = alt_word[(8'd39 - {tx_idx_reg, 3'b000}) -: 8];
  wire [7:0]           pay_byte     = tx_echo_reg ? buf_reg[tx_idx_reg[`BUF_AW-1:0]] : alt_byte;
  wire                 pay_is_dle   = (pay_byte == `DLE_BYTE);
  wire                 pay_last     = (tx_idx_reg == tx_len_reg - 1'b1);
  wire                 push_valid   = (state_reg == st_send);
  wire                 fifo_in_ready;
  wire                 push_ok      = push_valid && fifo_in_ready;
  wire                 send_done    = push_ok && (phase_reg == ph_taile);
  wire                 tx_chain     = send_done && tx_more_reg;
  wire [7:0]           push_byte    = (phase_reg == ph_err)   ? `ERR_ECHO_ID :
                                      (phase_reg == ph_id)    ? tx_id_reg    :
                                      (phase_reg == ph_data)  ? (pay_is_dle ? `DLE_BYTE : pay_byte) :
                                      (phase_reg == ph_stuff) ? pay_byte     :
                                      (phase_reg == ph_taile) ? `ETX_BYTE    :
                                                                `DLE_BYTE;
  wire                 fifo_out_valid;
  wire [7:0]           fifo_out_data;
  wire                 fifo_out_ready = !tx_valid_reg || tx_ready_in;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_byte),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  always_comb begin
    state_next  = state_reg;
    phase_next  = phase_reg;
    tx_idx_next = tx_idx_reg;
    case (state_reg)
      st_hunt: begin
        if (rx_take && rx_is_dle) begin
          state_next = st_id;
        end
      end
      st_id: begin
        if (rx_take && rx_is_etx) begin
          state_next = st_hunt;
        end else if (rx_take && id_ok) begin
          state_next = st_data;
        end
      end
      st_data: begin
        if (rx_take && rx_is_dle) begin
          state_next = st_esc;
        end
      end
      st_esc: begin
        if (frame_end) begin
          state_next  = tx_load ? st_send : st_hunt;
          phase_next  = ph_lead;
          tx_idx_next = '0;
        end else if (rx_take) begin
          state_next = st_data;
        end
      end
      st_send: begin
        if (push_ok) begin
          case (phase_reg)
            ph_lead:  phase_next = tx_echo_reg ? ph_err : ph_id;
            ph_err:   phase_next = ph_id;
            ph_id: begin
              phase_next  = (tx_len_reg == '0) ? ph_taild : ph_data;
              tx_idx_next = '0;
            end
            ph_data, ph_stuff: begin
              if (phase_reg == ph_data && pay_is_dle) begin
                phase_next = ph_stuff;
              end else begin
                phase_next  = pay_last ? ph_taild : ph_data;
                tx_idx_next = tx_idx_reg + 1'b1;
              end
            end
            ph_taild: phase_next = ph_taile;
            default: begin
              phase_next = ph_lead;
              state_next = tx_more_reg ? st_send : st_hunt;
            end
          endcase
        end
      end
      default: state_next = st_hunt;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_reg    <= st_send;
      phase_reg    <= ph_lead;
      tx_idx_reg   <= '0;
      rx_ready_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      phase_reg    <= phase_next;
      tx_idx_reg   <= tx_idx_next;
      rx_ready_reg <= (state_next != st_send);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rx_id_reg  <= '0;
      rx_len_reg <= '0;
      rx_bad_reg <= 1'b0;
    end else if (rx_take && in_id && id_ok) begin
      rx_id_reg  <= rx_data_in;
      rx_len_reg <= '0;
      rx_bad_reg <= 1'b0;
    end else begin
      if (rx_store && !rx_full) begin
        rx_len_reg <= rx_len_reg + 1'b1;
      end
      if (stuff_err || (rx_store && rx_full)) begin
        rx_bad_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rx_store && !rx_full) begin
      buf_reg[rx_len_reg[`BUF_AW-1:0]] <= rx_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tx_id_reg   <= `REP_VERSION;
      tx_len_reg  <= '0;
      tx_echo_reg <= 1'b0;
      tx_more_reg <= 1'b0;
    end else if (tx_load) begin
      tx_id_reg   <= parsed ? reply_id : rx_id_reg;
      tx_echo_reg <= !parsed;
      tx_len_reg  <= !parsed ? rx_len_reg : (ok_alt ? `LEN_ALT_REPORT : '0);
      tx_more_reg <= parsed && is_health;
    end else if (tx_chain) begin
      tx_id_reg   <= `REP_STATUS;
      tx_len_reg  <= '0;
      tx_echo_reg <= 1'b0;
      tx_more_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      restart_reg     <= 1'b0;
      erase_bbm_reg   <= 1'b0;
      erase_store_reg <= 1'b0;
      seed_valid_reg  <= 1'b0;
      ref_alt_reg     <= `ALT_RESET;
      alt_flag_reg    <= 1'b0;
      alt_2d_reg      <= '0;
    end else begin
      restart_reg     <= do_act && (ok_reset || is_soft);
      erase_bbm_reg   <= do_act && ok_reset;
      erase_store_reg <= do_act && ok_reset && (b0 == `MODE_FACTORY);
      seed_valid_reg  <= seed_load;
      if (do_act && alt_set) begin
        ref_alt_reg  <= {buf_reg[0], buf_reg[1], buf_reg[2], buf_reg[3]};
        alt_flag_reg <= 1'b1;
      end else if (do_act && alt_clear) begin
        alt_flag_reg <= 1'b0;
      end
      alt_2d_reg <= alt_flag_reg ? ref_alt_reg : last_3d_altitude_in;
    end
  end

  for (genvar a = 0; a < 3; a++) begin : g_axis
    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        seed_reg[a] <= '0;
      end else if (seed_load) begin
        seed_reg[a] <= {buf_reg[4*a], buf_reg[4*a+1], buf_reg[4*a+2], buf_reg[4*a+3]};
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tx_valid_reg  <= 1'b0;
      tx_data_reg   <= '0;
      last_push_reg <= '0;
    end else begin
      if (fifo_out_valid && fifo_out_ready) begin
        tx_valid_reg <= 1'b1;
        tx_data_reg  <= fifo_out_data;
      end else if (tx_ready_in) begin
        tx_valid_reg <= 1'b0;
      end
      if (push_ok) begin
        last_push_reg <= push_byte;
      end
    end
  end

  assign rx_ready_out                       = rx_ready_reg;
  assign tx_valid_out                       = tx_valid_reg;
  assign tx_data_out                        = tx_data_reg;
  assign restart_out                        = restart_reg;
  assign erase_battery_backed_memory_out    = erase_bbm_reg;
  assign erase_serial_nonvolatile_store_out = erase_store_reg;
  assign seed_valid_out                     = seed_valid_reg;
  assign seed_x_out                         = seed_reg[0];
  assign seed_y_out                         = seed_reg[1];
  assign seed_z_out                         = seed_reg[2];
  assign ref_altitude_out                   = ref_alt_reg;
  assign altitude_flag_out                  = alt_flag_reg;
  assign altitude_2d_out                    = alt_2d_reg;

  frame_tail_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    push_ok && phase_reg == ph_taile |-> push_byte == `ETX_BYTE && last_push_reg == `DLE_BYTE)
    else $error("terminator not preceded by escape");

  ident_legal_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    push_ok && phase_reg == ph_id |-> push_byte != `DLE_BYTE && push_byte != `ETX_BYTE)
    else $error("illegal identifier sent");

  stuff_pair_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    push_ok && phase_reg == ph_stuff |-> last_push_reg == `DLE_BYTE && push_byte == `DLE_BYTE)
    else $error("payload escape not doubled");

  odd_end_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    rx_take && in_data && rx_is_etx |=> state_reg == st_data &&
    (rx_len_reg == $past(rx_len_reg) + 1'b1 || $past(rx_full)))
    else $error("even escape run ended a packet");

  echo_code_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    push_ok && phase_reg == ph_err |-> tx_echo_reg && last_push_reg == `DLE_BYTE && push_byte == `ERR_ECHO_ID)
    else $error("echo code misplaced");

  reset_reply_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    do_act && ok_reset |=> restart_reg && erase_bbm_reg && tx_id_reg == `REP_STATUS && state_reg == st_send)
    else $error("reset command not carried out");

  seed_ignore_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    seed_valid_reg |-> $past(!computing_in) && seed_x_out == {$past(buf_reg[0]), $past(buf_reg[1]),
                                                               $past(buf_reg[2]), $past(buf_reg[3])})
    else $error("seed taken while computing or out of order");

  msg_silent_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    frame_end && parsed && is_msg && !msg_received_in |=> state_reg == st_hunt)
    else $error("system message reply without message");

  health_pair_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    tx_chain |=> tx_id_reg == `REP_STATUS && phase_reg == ph_lead && state_reg == st_send)
    else $error("status report not chained after health");

  alt_select_a: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    alt_flag_reg |=> altitude_2d_out == $past(ref_alt_reg))
    else $error("reference altitude not used");

endmodule

// [sim/host_link.sv]
`timescale 1ns/1ps

module host_link (
  input  wire logic sys_clk_in,
  input  wire logic slow_in,
  output logic      tx_ready_out
);
  // the host takes report bytes at once, or stalls at random when slow
  initial tx_ready_out = 1'b0;
  always @(negedge sys_clk_in) begin
    tx_ready_out <= slow_in ? ($urandom_range(0, 3) == 0) : 1'b1;
  end
endmodule

// [sim/tb_gps_serial_packet_command.sv]
`timescale 1ns/1ps
`include "packet_defines.svh"

module tb_gps_serial_packet_command;
  import packet_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        rx_valid_in = 1'b0;
  logic [7:0]  rx_data_in = 8'h00;
  logic        tx_ready_in;
  logic        computing_in = 1'b0;
  logic        msg_received_in = 1'b0;
  logic [31:0] last_3d_altitude_in = 32'h0000_0000;
  logic        slow_in = 1'b0;
  logic        rx_ready_out, tx_valid_out, restart_out, seed_valid_out, altitude_flag_out;
  logic        erase_battery_backed_memory_out, erase_serial_nonvolatile_store_out;
  logic [7:0]  tx_data_out;
  logic [31:0] seed_x_out, seed_y_out, seed_z_out, ref_altitude_out, altitude_2d_out;
  logic [7:0]  got_q[$];
  logic [7:0]  exp_q[$];
  logic [7:0]  pl_q[$];
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          restarts = 0;
  int          erase_b = 0;
  int          erase_s = 0;
  int          seeds = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  packet_command i_dut (.*);
  host_link i_host (.sys_clk_in(sys_clk_in), .slow_in(slow_in), .tx_ready_out(tx_ready_in));

  always @(posedge sys_clk_in) begin
    cycles++;
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) got_q.push_back(tx_data_out);
    if (restart_out === 1'b1) restarts++;
    if (erase_battery_backed_memory_out === 1'b1) erase_b++;
    if (erase_serial_nonvolatile_store_out === 1'b1) erase_s++;
    if (seed_valid_out === 1'b1) seeds++;
    if (cycles == 40000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic build(input logic [7:0] id, input bit echo, ref logic [7:0] q[$]);
    q.push_back(`DLE_BYTE);
    if (echo) q.push_back(`ERR_ECHO_ID);
    q.push_back(id);
    foreach (pl_q[i]) begin
      if (pl_q[i] === `DLE_BYTE) q.push_back(`DLE_BYTE);
      q.push_back(pl_q[i]);
    end
    q.push_back(`DLE_BYTE);
    q.push_back(`ETX_BYTE);
  endtask

  // stray bytes and a lone escape-terminator precede every frame
  task automatic run(input logic [7:0] id, input bit snd, input string name);
    logic [7:0] s[$];
    int         k;
    s = '{8'h55, 8'h03, 8'h10, 8'h03};
    build(id, 1'b0, s);
    if (snd) begin
      foreach (s[i]) begin
        @(negedge sys_clk_in);
        rx_valid_in = 1'b1;
        rx_data_in = s[i];
        do @(posedge sys_clk_in); while (rx_ready_out !== 1'b1);
      end
      @(negedge sys_clk_in);
      rx_valid_in = 1'b0;
    end
    k = 0;
    while (got_q.size() < exp_q.size() && k < 400) begin
      @(posedge sys_clk_in);
      k++;
    end
    repeat (30) @(posedge sys_clk_in);
    check({name, "_len"}, exp_q.size(), got_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) check(name, exp_q[i], got_q[i]);
    exp_q = {};
    got_q = {};
    pl_q = {};
    @(negedge sys_clk_in);
    $display("test %s done", name);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    logic [31:0] alt;
    logic [95:0] sd;
    logic [7:0]  req[5];
    logic [7:0]  rep[5];
    req = '{`CMD_VERSION, `CMD_TIME, `CMD_FIX_MODE, `CMD_HEALTH, `CMD_SIGNALS};
    rep = '{`REP_VERSION, `REP_TIME, `REP_FIX_MODE, `REP_HEALTH, `REP_SIGNALS};
    void'($urandom(32'h4EC1));
    last_3d_altitude_in = $urandom;
    repeat (20) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    build(`REP_VERSION, 1'b0, exp_q);
    run(8'h00, 1'b0, "power_up");
    for (int i = 0; i < 5; i++) begin
      slow_in = i[0];
      build(rep[i], 1'b0, exp_q);
      if (rep[i] == `REP_HEALTH) build(`REP_STATUS, 1'b0, exp_q);
      run(req[i], 1'b1, "request");
    end
    build(`REP_VERSION, 1'b0, exp_q);
    run(`CMD_SOFT_RESET, 1'b1, "soft_reset");
    check("restarts", 1, restarts);
    build(`REP_STATUS, 1'b0, exp_q);
    pl_q = '{`MODE_FACTORY};
    run(`CMD_CLEAR_RESET, 1'b1, "factory");
    build(`REP_STATUS, 1'b0, exp_q);
    pl_q = '{`MODE_COLD};
    run(`CMD_CLEAR_RESET, 1'b1, "cold");
    check("restarts", 3, restarts);
    check("erase_mem", 2, erase_b);
    check("erase_store", 1, erase_s);
    run(`CMD_SYS_MSG, 1'b1, "no_msg");
    msg_received_in = 1'b1;
    build(`REP_SYS_MSG, 1'b0, exp_q);
    run(`CMD_SYS_MSG, 1'b1, "msg");
    slow_in = 1'b1;
    alt = {`DLE_BYTE, 24'($urandom)};
    pl_q = '{alt[31:24], alt[23:16], alt[15:8], alt[7:0], 8'h01};
    build(`REP_ALTITUDE, 1'b0, exp_q);
    void'(pl_q.pop_back());
    run(`CMD_ALTITUDE, 1'b1, "alt_set");
    check("ref_alt", alt, ref_altitude_out);
    check("alt_flag", 1, altitude_flag_out);
    check("alt_2d", alt, altitude_2d_out);
    for (int i = 0; i < 2; i++) begin
      pl_q = '{alt[31:24], alt[23:16], alt[15:8], alt[7:0], 8'h00};
      build(`REP_ALTITUDE, 1'b0, exp_q);
      pl_q = {};
      if (i == 0) pl_q.push_back(`ALT_CLEAR_FLAG);
      run(`CMD_ALTITUDE, 1'b1, "alt_clear_query");
      check("alt_flag", 0, altitude_flag_out);
      check("alt_2d", last_3d_altitude_in, altitude_2d_out);
    end
    sd = {$urandom, $urandom, $urandom};
    for (int c = 0; c < 2; c++) begin
      computing_in = c[0];
      for (int i = 11; i >= 0; i--) pl_q.push_back(sd[i*8 +: 8]);
      run(`CMD_SEED_XYZ, 1'b1, "seed");
      check("seeds", 1, seeds);
    end
    check("seed_x", sd[95:64], seed_x_out);
    check("seed_y", sd[63:32], seed_y_out);
    check("seed_z", sd[31:0], seed_z_out);
    pl_q = '{8'h03, `DLE_BYTE};
    build(8'h2B, 1'b1, exp_q);
    run(8'h2B, 1'b1, "echo_unknown");
    pl_q = '{8'h01};
    build(`CMD_TIME, 1'b1, exp_q);
    run(`CMD_TIME, 1'b1, "echo_length");
    print_verdict();
  end
endmodule
